// file: shared/supervisor_pkg.sv
package supervisor_pkg;
    localparam int ADDR_W = 13;
    // Register byte addresses
    localparam logic [12:0] FLAGS_ADDR = 13'h1FF0;
    localparam logic [12:0] ALARM_EN_ADDR = 13'h1FF6;
    localparam logic [12:0] WATCHDOG_ADDR = 13'h1FF7;
    localparam logic [12:0] CLK_CTRL_ADDR = 13'h1FF8;
    localparam logic [12:0] CENTURY_ADDR = 13'h1FFC;
    // Field positions
    localparam int BATT_LOW_BIT = 4;
    localparam int REC_SEL_BIT = 7;
    localparam int FREQ_TEST_BIT = 6;
    localparam int CENT_EN_BIT = 5;
    localparam int CENT_TOGGLE_BIT = 4;
    localparam int ALARM_IRQ_BIT = 7;
    localparam int ALARM_BACKUP_BIT = 5;
    localparam int UPDATE_HOLD_BIT = 7;
    localparam int SNAPSHOT_HOLD_BIT = 6;
    // Reset, unmapped-read and last-year values
    localparam logic [7:0] WATCHDOG_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam logic [7:0] YEAR_LAST = 8'h99;
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int REC_SLOW_MIN_US = 40000;
    localparam int REC_FAST_MAX_US = 2000;
    localparam int REC_SLOW_CYCLES = REC_SLOW_MIN_US * CLK_MHZ;
    localparam int REC_FAST_CYCLES = REC_FAST_MAX_US * CLK_MHZ;
    localparam int REC_CNT_W = 23;
    typedef enum logic [1:0] {BACKUP, RECOVER, NORMAL} power_state_t;
endpackage

// file: rtl/sync2.sv
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
    parameter int W = 1
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [W-1:0] d, // Asynchronous input
    output logic [W-1:0] q // Synchronised output
);
    logic [W-1:0] stage1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            q <= '0;
        end else begin
            stage1 <= d;
            q <= stage1;
        end
    end
endmodule
`default_nettype wire

// file: rtl/supervisory_status.sv
`timescale 1ns/1ns
`default_nettype none
module supervisory_status #(
    parameter int SLOW_CYCLES = supervisor_pkg::REC_SLOW_CYCLES,
    parameter int FAST_CYCLES = supervisor_pkg::REC_FAST_CYCLES
) (
    input wire logic clk, // 100 MHz clock
    input wire logic rst_n, // Battery attach reset, active low
    input wire logic sysReset_n, // Subsequent reset pin, active low
    input wire logic supplyGood, // Supply above deselect trip level
    input wire logic oscRunning, // Oscillator running
    input wire logic batteryBelow, // Battery below low threshold
    input wire logic monitorBelow, // Supply monitor input below threshold
    input wire logic dayRollover, // Day rollover pulse, same clock
    input wire logic yearUpdate, // Year counter update pulse, same clock
    input wire logic [7:0] yearBcd, // Year counter value before update
    input wire logic chipEn_n, // Chip enable, active low
    input wire logic writeEn_n, // Write enable, active low
    input wire logic outEn_n, // Output enable, active low
    input wire logic [12:0] addr, // Byte address
    input wire logic [7:0] dataIn, // Data bus input
    output logic [7:0] dataOut, // Data bus output
    output logic dataOe_n, // Data bus drive, low drives
    output logic supplyMonitorOut, // Supply monitor output
    output logic resetOut_n, // Reset output, active low
    output logic [7:0] watchdogReg, // Watchdog control byte
    output logic alarmIrqEnable, // Alarm interrupt enable
    output logic alarmBackupEnable, // Alarm in back-up enable
    output logic clockUpdateHold, // Clock update hold
    output logic clockSnapshotHold, // Clock snapshot hold
    output logic freqTestOutEnable, // Frequency test output enable
    output logic centuryToggleBit // Century bit
);
    localparam int SYNC_W = 29;

    logic [SYNC_W-1:0] syncOut;
    logic sysResetS, supplyS, oscS, battS, monBelowS;
    logic ceS, weS, oeS;
    logic [12:0] addrS;
    logic [7:0] dataS;
    logic weLast;
    supervisor_pkg::power_state_t state, next_state;
    logic [supervisor_pkg::REC_CNT_W-1:0] recCount;
    logic sysResetLast;
    logic batteryLow;
    logic recoverySelect;
    logic centuryEnable;

    sync2 #(.W(SYNC_W)) pinSync (
        .clk(clk),
        .rst_n(rst_n),
        .d({sysReset_n, supplyGood, oscRunning, batteryBelow, monitorBelow,
            chipEn_n, writeEn_n, outEn_n, addr, dataIn}),
        .q(syncOut)
    );

    assign {sysResetS, supplyS, oscS, battS, monBelowS, ceS, weS, oeS, addrS, dataS} = syncOut;

    // Power sequencing
    wire recoverLimit = recoverySelect ? (recCount >= supervisor_pkg::REC_CNT_W'(FAST_CYCLES - 1))
                                       : (recCount >= supervisor_pkg::REC_CNT_W'(SLOW_CYCLES - 1));
    wire enterRecover = (state == supervisor_pkg::BACKUP) && supplyS;
    wire powerDown = (state != supervisor_pkg::BACKUP) && !supplyS;
    wire resetEdge = sysResetLast && !sysResetS;

    always_comb begin
        next_state = state;
        unique case (state)
            supervisor_pkg::BACKUP: begin
                if (supplyS) begin
                    next_state = supervisor_pkg::RECOVER;
                end
            end
            supervisor_pkg::RECOVER: begin
                if (!supplyS) begin
                    next_state = supervisor_pkg::BACKUP;
                end else if (recoverLimit) begin
                    next_state = supervisor_pkg::NORMAL;
                end
            end
            supervisor_pkg::NORMAL: begin
                if (!supplyS) begin
                    next_state = supervisor_pkg::BACKUP;
                end
            end
            default: begin
                next_state = supervisor_pkg::BACKUP;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= supervisor_pkg::BACKUP;
            recCount <= '0;
            sysResetLast <= 1'b0;
            weLast <= 1'b1;
        end else begin
            state <= next_state;
            sysResetLast <= sysResetS;
            weLast <= weS;
            if (state == supervisor_pkg::RECOVER) begin
                recCount <= recCount + 1'b1;
            end else begin
                recCount <= '0;
            end
        end
    end

    // Pin outputs
    assign supplyMonitorOut = (state == supervisor_pkg::NORMAL) ? !monBelowS
                            : (state == supervisor_pkg::RECOVER);
    assign resetOut_n = (state == supervisor_pkg::NORMAL);

    // Battery monitoring
    wire dailyCheck = dayRollover && oscS && (state == supervisor_pkg::NORMAL);
    wire batteryCheck = enterRecover || dailyCheck;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            batteryLow <= 1'b0;
        end else if (batteryCheck) begin
            batteryLow <= battS;
        end
    end

    // Host bus decode
    wire powered = (state == supervisor_pkg::NORMAL);
    wire writeStrobe = powered && !ceS && weS && !weLast;
    wire selAlarm = (addrS == supervisor_pkg::ALARM_EN_ADDR);
    wire selWatchdog = (addrS == supervisor_pkg::WATCHDOG_ADDR);
    wire selClkCtrl = (addrS == supervisor_pkg::CLK_CTRL_ADDR);
    wire selCentury = (addrS == supervisor_pkg::CENTURY_ADDR);
    wire selFlags = (addrS == supervisor_pkg::FLAGS_ADDR);
    wire wrAlarm = writeStrobe && selAlarm;
    wire wrWatchdog = writeStrobe && selWatchdog;
    wire wrClkCtrl = writeStrobe && selClkCtrl;
    wire wrCentury = writeStrobe && selCentury;
    wire centuryTurn = yearUpdate && (yearBcd == supervisor_pkg::YEAR_LAST);
    // Thirteen volatile bits cleared on power-up or reset
    wire clearAll = enterRecover || resetEdge;

    // Control bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            watchdogReg <= supervisor_pkg::WATCHDOG_RESET;
            alarmIrqEnable <= 1'b0;
            alarmBackupEnable <= 1'b0;
            clockUpdateHold <= 1'b0;
            clockSnapshotHold <= 1'b0;
            freqTestOutEnable <= 1'b0;
        end else if (clearAll) begin
            watchdogReg <= supervisor_pkg::WATCHDOG_RESET;
            alarmIrqEnable <= 1'b0;
            alarmBackupEnable <= 1'b0;
            clockUpdateHold <= 1'b0;
            clockSnapshotHold <= 1'b0;
            freqTestOutEnable <= 1'b0;
        end else if (powerDown) begin
            watchdogReg <= supervisor_pkg::WATCHDOG_RESET;
            clockUpdateHold <= 1'b0;
            clockSnapshotHold <= 1'b0;
            freqTestOutEnable <= 1'b0;
        end else begin
            if (wrWatchdog) begin
                watchdogReg <= dataS;
            end
            if (wrAlarm) begin
                alarmIrqEnable <= dataS[supervisor_pkg::ALARM_IRQ_BIT];
                alarmBackupEnable <= dataS[supervisor_pkg::ALARM_BACKUP_BIT];
            end
            if (wrClkCtrl) begin
                clockUpdateHold <= dataS[supervisor_pkg::UPDATE_HOLD_BIT];
                clockSnapshotHold <= dataS[supervisor_pkg::SNAPSHOT_HOLD_BIT];
            end
            if (wrCentury) begin
                freqTestOutEnable <= dataS[supervisor_pkg::FREQ_TEST_BIT];
            end
        end
    end

    // Retained bits, untouched by power cycles or reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            recoverySelect <= 1'b0;
            centuryEnable <= 1'b0;
            centuryToggleBit <= 1'b0;
        end else begin
            if (wrCentury) begin
                recoverySelect <= dataS[supervisor_pkg::REC_SEL_BIT];
                centuryEnable <= dataS[supervisor_pkg::CENT_EN_BIT];
            end
            if (centuryTurn && centuryEnable) begin
                centuryToggleBit <= !centuryToggleBit;
            end else if (wrCentury && clockUpdateHold) begin
                centuryToggleBit <= dataS[supervisor_pkg::CENT_TOGGLE_BIT];
            end
        end
    end

    // Read path; flags read has no side effect
    logic [7:0] flagsByte, alarmByte, clkCtrlByte, centuryByte, readMux;
    always_comb begin
        flagsByte = 8'h00;
        flagsByte[supervisor_pkg::BATT_LOW_BIT] = batteryLow;
        alarmByte = 8'h00;
        alarmByte[supervisor_pkg::ALARM_IRQ_BIT] = alarmIrqEnable;
        alarmByte[supervisor_pkg::ALARM_BACKUP_BIT] = alarmBackupEnable;
        clkCtrlByte = 8'h00;
        clkCtrlByte[supervisor_pkg::UPDATE_HOLD_BIT] = clockUpdateHold;
        clkCtrlByte[supervisor_pkg::SNAPSHOT_HOLD_BIT] = clockSnapshotHold;
        centuryByte = 8'h00;
        centuryByte[supervisor_pkg::REC_SEL_BIT] = recoverySelect;
        centuryByte[supervisor_pkg::FREQ_TEST_BIT] = freqTestOutEnable;
        centuryByte[supervisor_pkg::CENT_EN_BIT] = centuryEnable;
        centuryByte[supervisor_pkg::CENT_TOGGLE_BIT] = centuryToggleBit;
        readMux = supervisor_pkg::UNMAPPED_READ;
        if (selFlags) begin
            readMux = flagsByte;
        end else if (selAlarm) begin
            readMux = alarmByte;
        end else if (selWatchdog) begin
            readMux = watchdogReg;
        end else if (selClkCtrl) begin
            readMux = clkCtrlByte;
        end else if (selCentury) begin
            readMux = centuryByte;
        end
    end

    wire readActive = powered && !ceS && !oeS && weS;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dataOut <= 8'h00;
        end else begin
            dataOut <= readMux;
        end
    end

    assign dataOe_n = !readActive;

    // Checks
    logic [supervisor_pkg::REC_CNT_W-1:0] recWatch;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            recWatch <= '0;
        end else if (state == supervisor_pkg::RECOVER) begin
            recWatch <= recWatch + 1'b1;
        end else begin
            recWatch <= '0;
        end
    end

    a_backup_mon_low: assert property (@(posedge clk) disable iff (!rst_n)
        state == supervisor_pkg::BACKUP |-> !supplyMonitorOut && !resetOut_n)
        else $error("Monitor output not low in back-up");
    a_recover_mon_high: assert property (@(posedge clk) disable iff (!rst_n)
        state == supervisor_pkg::RECOVER |-> supplyMonitorOut && !resetOut_n)
        else $error("Monitor output not forced high in recovery");
    a_normal_follow: assert property (@(posedge clk) disable iff (!rst_n)
        state == supervisor_pkg::NORMAL |-> supplyMonitorOut == !monBelowS && resetOut_n)
        else $error("Monitor output does not follow comparator");
    a_fast_limit: assert property (@(posedge clk) disable iff (!rst_n)
        state == supervisor_pkg::RECOVER && recoverySelect |->
        recWatch < supervisor_pkg::REC_CNT_W'(FAST_CYCLES))
        else $error("Fast recovery exceeded its limit");
    a_slow_least: assert property (@(posedge clk) disable iff (!rst_n)
        $past(state) == supervisor_pkg::RECOVER && state == supervisor_pkg::NORMAL &&
        !recoverySelect |-> $past(recWatch) == supervisor_pkg::REC_CNT_W'(SLOW_CYCLES - 1))
        else $error("Slow recovery ended early");
    a_no_backup_check: assert property (@(posedge clk) disable iff (!rst_n)
        state == supervisor_pkg::BACKUP && !supplyS |=> $stable(batteryLow))
        else $error("Battery flag changed in back-up");
    a_powerup_clear: assert property (@(posedge clk) disable iff (!rst_n)
        enterRecover |=> !alarmIrqEnable && !alarmBackupEnable && !clockUpdateHold &&
        !clockSnapshotHold &&
        watchdogReg == supervisor_pkg::WATCHDOG_RESET && !freqTestOutEnable)
        else $error("Power-up defaults not applied");
    a_powerdown_keep: assert property (@(posedge clk) disable iff (!rst_n)
        powerDown && !clearAll |=> !clockUpdateHold && !clockSnapshotHold &&
        !freqTestOutEnable && $stable(alarmIrqEnable) && $stable(alarmBackupEnable))
        else $error("Power-down defaults wrong");
    a_century_toggle: assert property (@(posedge clk) disable iff (!rst_n)
        centuryTurn && centuryEnable |=> centuryToggleBit != $past(centuryToggleBit))
        else $error("Century bit did not toggle");
    a_century_gate: assert property (@(posedge clk) disable iff (!rst_n)
        !(centuryTurn && centuryEnable) && !clockUpdateHold |=> $stable(centuryToggleBit))
        else $error("Century bit changed without hold");
    a_battery_sample: assert property (@(posedge clk) disable iff (!rst_n)
        batteryCheck |=> batteryLow == $past(battS))
        else $error("Battery check result not captured");

    c_full_recovery: cover property (@(posedge clk) disable iff (!rst_n)
        state == supervisor_pkg::RECOVER ##1 state == supervisor_pkg::NORMAL);
    c_daily_low: cover property (@(posedge clk) disable iff (!rst_n)
        dailyCheck && battS);
    c_century_turn: cover property (@(posedge clk) disable iff (!rst_n)
        centuryTurn && centuryEnable);
endmodule
`default_nettype wire

// file: sim/host_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input wire logic clk, // System clock
    output logic chipEn_n, // Chip enable, active low
    output logic writeEn_n, // Write enable, active low
    output logic outEn_n, // Output enable, active low
    output logic [12:0] addr, // Byte address
    output logic [7:0] dataIn, // Data toward device
    input wire logic [7:0] dataOut, // Read data
    input wire logic dataOe_n // Device drives bus, low
);
    initial begin
        chipEn_n = 1'b1;
        writeEn_n = 1'b1;
        outEn_n = 1'b1;
        addr = 13'h0000;
        dataIn = 8'h00;
    end

    // Strobe low and high for four cycles each, address and data held throughout
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        dataIn = d;
        chipEn_n = 1'b0;
        writeEn_n = 1'b0;
        repeat (4) @(negedge clk);
        writeEn_n = 1'b1;
        repeat (4) @(negedge clk);
        chipEn_n = 1'b1;
        dataIn = ~d;
    endtask

    task automatic rd(input logic [12:0] a, output logic [7:0] d, output logic oe_n);
        @(negedge clk);
        addr = a;
        chipEn_n = 1'b0;
        outEn_n = 1'b0;
        repeat (5) @(negedge clk);
        d = dataOut;
        oe_n = dataOe_n;
        chipEn_n = 1'b1;
        outEn_n = 1'b1;
        repeat (3) @(negedge clk);
    endtask

    // Update hold raised around the century register write
    task automatic centuryWrite(input logic [7:0] d);
        wr(supervisor_pkg::CLK_CTRL_ADDR, 8'h80);
        wr(supervisor_pkg::CENTURY_ADDR, d);
        wr(supervisor_pkg::CLK_CTRL_ADDR, 8'h00);
    endtask
endmodule
`default_nettype wire

// file: sim/supervisory_status_test.sv
`timescale 1ns/1ns
`default_nettype none
module supervisory_status_test;
    localparam int SLOW = 40;
    localparam int FAST = 5;
    logic clk, rst_n, sysReset_n, supplyGood, oscRunning, batteryBelow, monitorBelow;
    logic dayRollover, yearUpdate;
    logic [7:0] yearBcd;
    wire logic chipEn_n, writeEn_n, outEn_n, dataOe_n, supplyMonitorOut, resetOut_n;
    wire logic alarmIrqEnable, alarmBackupEnable, clockUpdateHold, clockSnapshotHold;
    wire logic freqTestOutEnable, centuryToggleBit;
    wire logic [12:0] addr;
    wire logic [7:0] dataIn, dataOut, watchdogReg;
    wire logic [12:0] ctl = {watchdogReg, alarmIrqEnable, alarmBackupEnable, clockUpdateHold,
        clockSnapshotHold, freqTestOutEnable};
    int err_count, checked, i;
    integer seed;
    logic tr, ceb, cb, flag, osc, below;
    logic [7:0] wd;
    logic [7:0] years [5] = '{8'h99, 8'h98, 8'h99, 8'h00, 8'h49};

    supervisory_status #(.SLOW_CYCLES(SLOW), .FAST_CYCLES(FAST)) dut (.clk(clk), .rst_n(rst_n),
        .sysReset_n(sysReset_n), .supplyGood(supplyGood), .oscRunning(oscRunning),
        .batteryBelow(batteryBelow), .monitorBelow(monitorBelow), .dayRollover(dayRollover),
        .yearUpdate(yearUpdate), .yearBcd(yearBcd), .chipEn_n(chipEn_n), .writeEn_n(writeEn_n),
        .outEn_n(outEn_n), .addr(addr), .dataIn(dataIn), .dataOut(dataOut), .dataOe_n(dataOe_n),
        .supplyMonitorOut(supplyMonitorOut), .resetOut_n(resetOut_n), .watchdogReg(watchdogReg),
        .alarmIrqEnable(alarmIrqEnable), .alarmBackupEnable(alarmBackupEnable),
        .clockUpdateHold(clockUpdateHold), .clockSnapshotHold(clockSnapshotHold),
        .freqTestOutEnable(freqTestOutEnable), .centuryToggleBit(centuryToggleBit));
    host_model host (.clk(clk), .chipEn_n(chipEn_n), .writeEn_n(writeEn_n), .outEn_n(outEn_n),
        .addr(addr), .dataIn(dataIn), .dataOut(dataOut), .dataOe_n(dataOe_n));

    initial clk = 1'b0;
    always #5 clk = ~clk;

    function automatic logic centNext(logic c, logic en, logic [7:0] y);
        return (en && y == 8'h99) ? !c : c;
    endfunction

    function automatic logic flagNext(logic prev, logic running, logic low);
        return running ? low : prev;
    endfunction

    task automatic results();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic rdChk(input logic [12:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic oe;
        host.rd(a, d, oe);
        check(oe, 1'b0);
        check(d, exp);
    endtask

    task automatic powerUp(input int cyc);
        int n;
        n = 0;
        supplyGood = 1'b1;
        while (resetOut_n !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 3 && resetOut_n !== 1'b1) check(supplyMonitorOut, 1'b1);
            if (n > 1000) begin
                err_count++;
                results();
            end
        end
        check(n >= cyc && n <= cyc + 5, 1'b1);
        check(supplyMonitorOut, !monitorBelow);
    endtask

    task automatic setCtl();
        wd = 8'($random(seed)) | 8'h01;
        host.wr(supervisor_pkg::ALARM_EN_ADDR, 8'hA0);
        host.wr(supervisor_pkg::WATCHDOG_ADDR, wd);
        host.centuryWrite({tr, 1'b1, ceb, cb, 4'h0});
        host.wr(supervisor_pkg::CLK_CTRL_ADDR, 8'hC0);
        check(ctl, {wd, 5'h1F});
    endtask

    task automatic yearStep(input logic [7:0] y);
        cb = centNext(cb, ceb, y);
        yearBcd = y;
        yearUpdate = 1'b1;
        @(negedge clk);
        yearUpdate = 1'b0;
        @(negedge clk);
        check(centuryToggleBit, cb);
    endtask

    initial begin
        seed = 32'h3B1B0BEC;
        err_count = 0;
        checked = 0;
        {rst_n, supplyGood, dayRollover, yearUpdate, yearBcd} = 12'h000;
        {sysReset_n, oscRunning, batteryBelow, monitorBelow} = 4'hF;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        check(ctl, 13'h0000);
        check({supplyMonitorOut, resetOut_n}, 2'b00);
        repeat (3) @(negedge clk);
        powerUp(SLOW);
        flag = 1'b1;
        rdChk(supervisor_pkg::FLAGS_ADDR, 8'h10);
        host.wr(supervisor_pkg::FLAGS_ADDR, 8'h00);
        rdChk(supervisor_pkg::FLAGS_ADDR, 8'h10);
        rdChk(13'h1FF1, supervisor_pkg::UNMAPPED_READ);
        for (i = 0; i < 5; i++) begin
            osc = (i == 4) ? 1'b1 : 1'($random(seed));
            below = (i == 4) ? 1'b1 : 1'($random(seed));
            oscRunning = osc;
            batteryBelow = below;
            repeat (4) @(negedge clk);
            dayRollover = 1'b1;
            @(negedge clk);
            dayRollover = 1'b0;
            repeat (2) @(negedge clk);
            flag = flagNext(flag, osc, below);
            rdChk(supervisor_pkg::FLAGS_ADDR, {3'b000, flag, 4'h0});
        end
        for (i = 0; i < 8; i++) begin
            monitorBelow = 1'($random(seed));
            repeat (3) @(negedge clk);
            check(supplyMonitorOut, !monitorBelow);
        end
        {tr, ceb, cb} = {2'b11, 1'($random(seed))};
        host.centuryWrite({tr, 1'b0, ceb, cb, 4'h0});
        check(centuryToggleBit, cb);
        foreach (years[k]) yearStep(years[k]);
        ceb = 1'b0;
        host.centuryWrite({tr, 1'b0, ceb, cb, 4'h0});
        yearStep(8'h99);
        host.wr(supervisor_pkg::CENTURY_ADDR, {tr, 1'b0, ceb, ~cb, 4'h0});
        check(centuryToggleBit, cb);
        rdChk(supervisor_pkg::CENTURY_ADDR, {tr, 1'b0, ceb, cb, 4'h0});
        setCtl();
        sysReset_n = 1'b0;
        repeat (6) @(negedge clk);
        sysReset_n = 1'b1;
        check(ctl, 13'h0000);
        rdChk(supervisor_pkg::CENTURY_ADDR, {tr, 1'b0, ceb, cb, 4'h0});
        setCtl();
        monitorBelow = 1'b1;
        batteryBelow = 1'b0;
        supplyGood = 1'b0;
        repeat (4) @(negedge clk);
        check(ctl, 13'h0018);
        check({supplyMonitorOut, resetOut_n}, 2'b00);
        powerUp(FAST);
        check(ctl, 13'h0000);
        rdChk(supervisor_pkg::FLAGS_ADDR, 8'h00);
        results();
    end
endmodule
`default_nettype wire
